//--- bench/rdaf_host_model.sv
// rdaf_host_model: reply serialiser and host on the far side.
// assumes ack pulses from the drive; answers fast or slow.
`timescale 1ns/1ps

module rdaf_host_model (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // reply side
  input  wire logic i_ack_req,
  input  wire logic i_slow,
  output logic      o_reply_done
);
  // ***************************************************************
  // reply length counter
  // ***************************************************************
  logic [7:0] left;
  logic [7:0] next_left;
  logic       next_done;

  // one host only, it listens until the reply ends
  always_comb begin
    next_done = (left == 8'h1);
    next_left = (left != 8'h0) ? left - 8'h1 : 8'h0;
    if (i_ack_req) begin
      next_left = i_slow ? 8'h28 : 8'h03;
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      left         <= 8'h0;
      o_reply_done <= 1'b0;
    end else begin
      left         <= next_left;
      o_reply_done <= next_done;
    end
  end
endmodule // rdaf_host_model

//--- bench/rdaf_sva.sv
// rdaf_sva: port assertions for rdaf_top.
// assumes one clock domain; attached by the bind at the foot.
`timescale 1ns/1ps

module rdaf_sva #(
  parameter int CYC_PER_MS = rdaf_pkg::CYC_PER_MS
) (
  // clock and reset
  input wire logic       I_CLK_SYS,
  input wire logic       I_ARST_N,
  // inputs
  input wire logic [7:0] I_RX_DATA,
  input wire logic       I_RX_VALID,
  input wire logic       I_TWO_WIRE,
  input wire logic       I_REPLY_DONE,
  // outputs
  input wire logic [7:0] O_CMD_DATA,
  input wire logic       O_CMD_VALID,
  input wire logic       O_CMD_END,
  input wire logic       O_CMD_GLOBAL,
  input wire logic       O_ACK_REQ,
  input wire logic       O_TX_EN,
  input wire logic [7:0] O_NODE_ADDR,
  input wire logic [7:0] O_DELAY_MS
);
  // ***************************************************************
  // cycles since the last command end
  // ***************************************************************
  logic [31:0] since_end;
  logic [31:0] next_since_end;

  // 32 bits never wraps within a 255 ms delay
  always_comb begin
    next_since_end = O_CMD_END ? 32'h0 : since_end + 32'h1;
  end
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      since_end <= 32'h0;
    end else begin
      since_end <= next_since_end;
    end
  end

  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_ARST_N);

  a_valid_from_rx: assert property (O_CMD_VALID |-> $past(I_RX_VALID)
    && O_CMD_DATA == $past(I_RX_DATA)) else $error("cmd byte not from rx");
  a_end_on_cr: assert property (O_CMD_END |-> $past(I_RX_VALID)
    && $past(I_RX_DATA) == rdaf_pkg::CHAR_CR) else $error("end without cr");
  a_ack_with_tx: assert property ($rose(O_TX_EN) |-> O_ACK_REQ)
    else $error("tx enabled without ack");
  a_ack_one_cycle: assert property (O_ACK_REQ |=> !O_ACK_REQ)
    else $error("ack longer than one cycle");
  a_no_ack_global: assert property (O_ACK_REQ |-> !O_CMD_GLOBAL)
    else $error("ack on global command");
  a_tx_release: assert property (O_TX_EN && I_REPLY_DONE |=> !O_TX_EN)
    else $error("tx not released");
  a_tx_wait_delay: assert property ($rose(O_TX_EN) && I_TWO_WIRE |->
    since_end + 32'h2 >= 32'(O_DELAY_MS) * 32'(CYC_PER_MS))
    else $error("tx before delay");
  a_four_wire_fast: assert property (O_CMD_END && !O_CMD_GLOBAL
    && !I_TWO_WIRE |-> ##[1:4] O_TX_EN) else $error("four-wire reply late");
  a_addr_legal: assert property (O_NODE_ADDR >= rdaf_pkg::CHAR_PUNCT1_LO
    && O_NODE_ADDR <= rdaf_pkg::CHAR_PUNCT2_HI) else $error("illegal addr");
endmodule // rdaf_sva

bind rdaf_top rdaf_sva #(.CYC_PER_MS(CYC_PER_MS)) u_sva (
  .I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N), .I_RX_DATA(I_RX_DATA),
  .I_RX_VALID(I_RX_VALID), .I_TWO_WIRE(I_TWO_WIRE),
  .I_REPLY_DONE(I_REPLY_DONE), .O_CMD_DATA(O_CMD_DATA),
  .O_CMD_VALID(O_CMD_VALID), .O_CMD_END(O_CMD_END),
  .O_CMD_GLOBAL(O_CMD_GLOBAL), .O_ACK_REQ(O_ACK_REQ), .O_TX_EN(O_TX_EN),
  .O_NODE_ADDR(O_NODE_ADDR), .O_DELAY_MS(O_DELAY_MS));

//--- bench/rdaf_top_tb.sv
// rdaf_top_tb: self-checking bench for rdaf_top.
// assumes rdaf_pkg, the checker bind and the host model.
`timescale 1ns/1ps

module rdaf_top_tb;
  // ***************************************************************
  // signals and scoreboard
  // ***************************************************************
  logic       clk = 1'b0;
  logic       arst_n, rx_valid, two_wire, addr_we, delay_we, slow;
  logic [7:0] rx_data, cfg_addr, cfg_delay;
  logic [7:0] cmd_data, node_addr, delay_ms;
  logic       cmd_valid, cmd_end, cmd_global, reply_done, ack_req, tx_en;
  logic [8:0] exp_q[$];
  logic [7:0] lfsr = 8'h26;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         n_ack = 0;
  int         cyc;
  // scaled millisecond keeps the delay tests short
  localparam int CPM = 1000;

  always #5 clk = ~clk;

  rdaf_top #(.CYC_PER_MS(CPM)) u_dut (.I_CLK_SYS(clk), .I_ARST_N(arst_n),
    .I_RX_DATA(rx_data),
    .I_RX_VALID(rx_valid), .I_TWO_WIRE(two_wire), .I_CFG_ADDR(cfg_addr),
    .I_CFG_ADDR_WE(addr_we), .I_CFG_DELAY_MS(cfg_delay),
    .I_CFG_DELAY_WE(delay_we), .O_CMD_DATA(cmd_data),
    .O_CMD_VALID(cmd_valid), .O_CMD_END(cmd_end), .O_CMD_GLOBAL(cmd_global),
    .I_REPLY_DONE(reply_done), .O_ACK_REQ(ack_req), .O_TX_EN(tx_en),
    .O_NODE_ADDR(node_addr), .O_DELAY_MS(delay_ms));
  rdaf_host_model u_host (.i_clk(clk), .i_arst_n(arst_n),
    .i_ack_req(ack_req), .i_slow(slow), .o_reply_done(reply_done));

  function automatic logic [7:0] step(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // bytes back to back; skip < 0 means the whole frame is dropped
  task automatic send(input string s, input int skip);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = s[i];
      if (skip >= 0 && i >= skip) exp_q.push_back({i == s.len() - 1, s[i]});
    end
    @(negedge clk);
    rx_valid = 1'b0;
    repeat (60) @(negedge clk);
  endtask

  task automatic cfg(input logic [7:0] v, input logic dly);
    @(negedge clk);
    cfg_addr = v;
    cfg_delay = v;
    addr_we = !dly;
    delay_we = dly;
    @(negedge clk);
    addr_we = 1'b0;
    delay_we = 1'b0;
    @(negedge clk);
  endtask

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // monitor: every forwarded byte takes the oldest note
  always @(posedge clk) begin
    if (ack_req === 1'b1) n_ack++;
    if (cmd_valid === 1'b1 || cmd_end === 1'b1) begin
      if (exp_q.size() == 0) chk("cmd", 9'h1ff, {cmd_end, cmd_data});
      else chk("cmd", exp_q.pop_front(), {cmd_end, cmd_data});
    end
  end

  // watchdog, several times the expected run of about 1,300 cycles
  initial begin
    #100_000;
    n_mismatch++;
    results();
  end

  initial begin
    {arst_n, rx_valid, two_wire, addr_we, delay_we, slow} = 6'h0;
    {rx_data, cfg_addr, cfg_delay} = 24'h0;
    repeat (16) @(negedge clk);
    chk("addr", {1'b0, rdaf_pkg::DEFAULT_ADDR}, {1'b0, node_addr});
    chk("delay", 9'h0, {1'b0, delay_ms});
    arst_n = 1'b1;
    send("0TD1\r", 1);
    chk("delay", 9'h1, {1'b0, delay_ms});
    chk("acks", 9'h1, 9'(n_ack));
    lfsr = step(lfsr);
    send($sformatf("FL%0d\r", lfsr % 10), 0);
    chk("global", 9'h1, {8'h0, cmd_global});
    chk("acks", 9'h1, 9'(n_ack));
    send("1FL2\r", -1);
    chk("acks", 9'h1, 9'(n_ack));
    slow = 1'b1;
    send("0DA7\r", 1);
    chk("addr", 9'h37, {1'b0, node_addr});
    chk("acks", 9'h2, 9'(n_ack));
    chk("global", 9'h0, {8'h0, cmd_global});
    cfg(8'h5a, 1'b0);
    chk("addr", 9'h37, {1'b0, node_addr});
    cfg(8'h23, 1'b0);
    chk("addr", 9'h23, {1'b0, node_addr});
    // real hosts want about ten ms; one scaled ms is enough here
    two_wire = 1'b1;
    slow = 1'b0;
    send("#FL1\r", 1);
    cyc = 0;
    while (tx_en !== 1'b1 && cyc < 2 * CPM) begin
      @(negedge clk);
      cyc++;
    end
    // tx rises one ms plus two edges after the CR; send spent 61 already
    chk("tx wait", 9'h1, {8'h0, cyc >= CPM - 61 && cyc <= CPM - 57});
    repeat (20) @(negedge clk);
    chk("tx off", 9'h0, {8'h0, tx_en});
    chk("acks", 9'h3, 9'(n_ack));
    cfg(8'h05, 1'b1);
    chk("delay", 9'h5, {1'b0, delay_ms});
    chk("queue", 9'h0, 9'(exp_q.size()));
    results();
  end
endmodule // rdaf_top_tb

//--- rtl/rdaf_pkg.sv
// rdaf_pkg: constants for the rs-485 drive address filter.
// assumes a 100 MHz system clock and ascii characters on a byte stream.
package rdaf_pkg;

  // ***************************************************************
  // character codes
  // ***************************************************************
  localparam logic [7:0] CHAR_CR        = 8'h0d;
  localparam logic [7:0] CHAR_DIGIT_LO  = 8'h30;
  localparam logic [7:0] CHAR_DIGIT_HI  = 8'h39;
  localparam logic [7:0] CHAR_PUNCT1_LO = 8'h21;
  localparam logic [7:0] CHAR_PUNCT1_HI = 8'h2f;
  localparam logic [7:0] CHAR_PUNCT2_LO = 8'h3a;
  localparam logic [7:0] CHAR_PUNCT2_HI = 8'h40;
  // factory address shared by every drive
  localparam logic [7:0] DEFAULT_ADDR   = 8'h30;
  // two-letter command codes
  localparam logic [7:0] CMD_ADDR_C0    = 8'h44;
  localparam logic [7:0] CMD_ADDR_C1    = 8'h41;
  localparam logic [7:0] CMD_DELAY_C0   = 8'h54;
  localparam logic [7:0] CMD_DELAY_C1   = 8'h44;
  localparam logic [7:0] CHAR_ZERO      = 8'h30;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_HZ          = 100_000_000;
  localparam int CYC_PER_MS      = CLK_HZ / 1000;
  localparam int DELAY_MS_W      = 8;
  localparam logic [7:0] DELAY_MS_DEFAULT = 8'h00;

  // frame states, gray coded around idle-body-wait-reply and idle-skip
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_BODY  = 3'b001,
    ST_WAIT  = 3'b011,
    ST_REPLY = 3'b010,
    ST_SKIP  = 3'b100
  } rdaf_state_type;

endpackage

//--- rtl/rdaf_top.sv
// rdaf_top: address filter and reply gate for one drive on rs-485.
// assumes a uart delivers received bytes as one-cycle strobes and that
// the reply serialiser starts on an ack pulse and reports when done.
// the reply text itself is built outside; this block only gates it.
`timescale 1ns/1ps

module rdaf_top #(
  parameter int MAX_LEN    = 32,
  // clock cycles per millisecond tick of the reply delay
  parameter int CYC_PER_MS = rdaf_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_ARST_N,
  // received byte stream
  input  wire logic [7:0] I_RX_DATA,
  input  wire logic       I_RX_VALID,
  // configuration
  input  wire logic       I_TWO_WIRE,
  input  wire logic [7:0] I_CFG_ADDR,
  input  wire logic       I_CFG_ADDR_WE,
  input  wire logic [7:0] I_CFG_DELAY_MS,
  input  wire logic       I_CFG_DELAY_WE,
  // command out to the motion engine
  output logic [7:0]      O_CMD_DATA,
  output logic            O_CMD_VALID,
  output logic            O_CMD_END,
  output logic            O_CMD_GLOBAL,
  // reply side
  input  wire logic       I_REPLY_DONE,
  output logic            O_ACK_REQ,
  output logic            O_TX_EN,
  // status
  output logic [7:0]      O_NODE_ADDR,
  output logic [7:0]      O_DELAY_MS
);

  // ***************************************************************
  // helpers
  // ***************************************************************
  // legal address characters: digits and the listed punctuation
  function automatic logic addr_legal(input logic [7:0] c);
    addr_legal = (c >= rdaf_pkg::CHAR_DIGIT_LO &&
                  c <= rdaf_pkg::CHAR_DIGIT_HI) ||
                 (c >= rdaf_pkg::CHAR_PUNCT1_LO &&
                  c <= rdaf_pkg::CHAR_PUNCT1_HI) ||
                 (c >= rdaf_pkg::CHAR_PUNCT2_LO &&
                  c <= rdaf_pkg::CHAR_PUNCT2_HI);
  endfunction

  // digits only; the decimal delay argument relies on it
  function automatic logic is_digit(input logic [7:0] c);
    is_digit = c >= rdaf_pkg::CHAR_DIGIT_LO && c <= rdaf_pkg::CHAR_DIGIT_HI;
  endfunction

  // counter widths follow the parameters
  localparam int LEN_W = $clog2(MAX_LEN + 1);
  localparam int CNT_W = $clog2(CYC_PER_MS + 1);
  localparam logic [CNT_W-1:0] CYC_MS_LAST =
    CNT_W'(CYC_PER_MS - 1);

  // ***************************************************************
  // state
  // ***************************************************************
  rdaf_pkg::rdaf_state_type state, next_state;
  logic [7:0]       node_addr, next_node_addr;
  logic [7:0]       delay_ms, next_delay_ms;
  // frame decode
  logic             addressed, next_addressed;
  logic [LEN_W-1:0] len, next_len;
  logic [7:0]       c0, next_c0;
  logic [7:0]       c1, next_c1;
  logic [7:0]       arg, next_arg;
  logic             arg_ok, next_arg_ok;
  // reply timing
  logic [CNT_W-1:0] cyc, next_cyc;
  logic [7:0]       ms_left, next_ms_left;
  // registered outputs
  logic [7:0]       cmd_data, next_cmd_data;
  logic             cmd_valid, next_cmd_valid;
  logic             cmd_end, next_cmd_end;
  logic             cmd_global, next_cmd_global;
  logic             ack_req, next_ack_req;
  logic             tx_en, next_tx_en;

  // ***************************************************************
  // next-state logic
  // ***************************************************************
  // one pass per clock cycle; address and delay writes are held here
  always_comb begin
    next_state      = state;
    next_node_addr  = node_addr;
    next_delay_ms   = delay_ms;
    next_addressed  = addressed;
    next_len        = len;
    next_c0         = c0;
    next_c1         = c1;
    next_arg        = arg;
    next_arg_ok     = arg_ok;
    next_cyc        = cyc;
    next_ms_left    = ms_left;
    next_cmd_data   = I_RX_DATA;
    next_cmd_valid  = 1'b0;
    next_cmd_end    = 1'b0;
    next_cmd_global = cmd_global;
    next_ack_req    = 1'b0;
    next_tx_en      = tx_en;

    // configuration port writes
    if (I_CFG_ADDR_WE && addr_legal(I_CFG_ADDR)) begin
      next_node_addr = I_CFG_ADDR;
    end
    if (I_CFG_DELAY_WE) begin
      next_delay_ms = I_CFG_DELAY_MS;
    end

    unique case (state)
      // first byte decides own, foreign or global frame;
      // a stray terminator between frames is ignored
      rdaf_pkg::ST_IDLE: begin
        if (I_RX_VALID && I_RX_DATA != rdaf_pkg::CHAR_CR) begin
          next_len    = '0;
          next_arg    = '0;
          next_arg_ok = 1'b1;
          if (I_RX_DATA == node_addr) begin
            // own prefix: executed and acknowledged
            next_addressed  = 1'b1;
            next_cmd_global = 1'b0;
            next_state      = rdaf_pkg::ST_BODY;
          end else if (addr_legal(I_RX_DATA)) begin
            // another drive's prefix: dropped silently
            next_state = rdaf_pkg::ST_SKIP;
          end else begin
            // letters start a global command, no ack
            next_addressed  = 1'b0;
            next_cmd_global = 1'b1;
            next_c0         = I_RX_DATA;
            next_len        = LEN_W'(1);
            next_cmd_valid  = 1'b1;
            next_state      = rdaf_pkg::ST_BODY;
          end
        end
      end

      // command characters pass through; the terminator closes the frame
      rdaf_pkg::ST_BODY: begin
        if (I_RX_VALID) begin
          if (I_RX_DATA == rdaf_pkg::CHAR_CR) begin
            next_cmd_end = 1'b1;
            // a global frame of this kind renames every drive at once
            // set-node-address: argument is the new address character
            if (len == LEN_W'(3) && c0 == rdaf_pkg::CMD_ADDR_C0 &&
                c1 == rdaf_pkg::CMD_ADDR_C1 && addr_legal(arg)) begin
              next_node_addr = arg;
            end
            // reply-delay: decimal argument in milliseconds
            if (len > LEN_W'(2) && arg_ok &&
                c0 == rdaf_pkg::CMD_DELAY_C0 &&
                c1 == rdaf_pkg::CMD_DELAY_C1) begin
              next_delay_ms = arg;
            end
            if (addressed) begin
              next_cyc     = '0;
              // four-wire ignores the delay and answers at once,
              // since the reply travels on a pair of its own
              next_ms_left = I_TWO_WIRE ? next_delay_ms : 8'h00;
              next_state   = rdaf_pkg::ST_WAIT;
            end else begin
              next_state = rdaf_pkg::ST_IDLE;
            end
          end else begin
            next_cmd_valid = 1'b1;
            // saturate so an over-long frame never wraps onto the opcode
            if (len < LEN_W'(MAX_LEN)) begin
              next_len = len + LEN_W'(1);
            end
            if (len == '0) begin
              next_c0 = I_RX_DATA;
            end else if (len == LEN_W'(1)) begin
              next_c1 = I_RX_DATA;
            end else if (len == LEN_W'(2)) begin
              next_arg = I_RX_DATA;
            end
            // accumulate decimal value for the delay command
            if (len >= LEN_W'(2)) begin
              if (!is_digit(I_RX_DATA)) begin
                next_arg_ok = 1'b0;
              end else if (c0 == rdaf_pkg::CMD_DELAY_C0) begin
                next_arg = 8'((len == LEN_W'(2) ? 8'h00 : arg) * 8'h0a +
                              (I_RX_DATA - rdaf_pkg::CHAR_ZERO));
              end
            end
          end
        end
      end

      // foreign frame: swallow bytes up to the terminator
      rdaf_pkg::ST_SKIP: begin
        if (I_RX_VALID && I_RX_DATA == rdaf_pkg::CHAR_CR) begin
          next_state = rdaf_pkg::ST_IDLE;
        end
      end

      // bytes arriving now are dropped; the host must stay quiet
      rdaf_pkg::ST_WAIT: begin
        // millisecond tick keeps the counter small at 100 MHz
        // a delay of zero enables the driver on the next edge
        if (ms_left == 8'h00) begin
          next_tx_en   = 1'b1;
          next_ack_req = 1'b1;
          next_state   = rdaf_pkg::ST_REPLY;
        end else if (cyc == CYC_MS_LAST) begin
          next_cyc     = '0;
          next_ms_left = ms_left - 8'h01;
        end else begin
          next_cyc = cyc + CNT_W'(1);
        end
      end

      // hold the driver until the serialiser reports the end
      rdaf_pkg::ST_REPLY: begin
        // release the pair so the host may transmit again
        if (I_REPLY_DONE) begin
          next_tx_en = 1'b0;
          next_state = rdaf_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  // every drive leaves reset with the same address
  // reset also drops any frame that was in flight
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state      <= rdaf_pkg::ST_IDLE;
      node_addr  <= rdaf_pkg::DEFAULT_ADDR;
      delay_ms   <= rdaf_pkg::DELAY_MS_DEFAULT;
      addressed  <= 1'b0;
      len        <= '0;
      c0         <= 8'h00;
      c1         <= 8'h00;
      arg        <= 8'h00;
      arg_ok     <= 1'b0;
      cyc        <= '0;
      ms_left    <= 8'h00;
      cmd_data   <= 8'h00;
      cmd_valid  <= 1'b0;
      cmd_end    <= 1'b0;
      cmd_global <= 1'b0;
      ack_req    <= 1'b0;
      tx_en      <= 1'b0;
    end else begin
      state      <= next_state;
      node_addr  <= next_node_addr;
      delay_ms   <= next_delay_ms;
      addressed  <= next_addressed;
      len        <= next_len;
      c0         <= next_c0;
      c1         <= next_c1;
      arg        <= next_arg;
      arg_ok     <= next_arg_ok;
      cyc        <= next_cyc;
      ms_left    <= next_ms_left;
      cmd_data   <= next_cmd_data;
      cmd_valid  <= next_cmd_valid;
      cmd_end    <= next_cmd_end;
      cmd_global <= next_cmd_global;
      ack_req    <= next_ack_req;
      tx_en      <= next_tx_en;
    end
  end

  // outputs straight from flip-flops
  // so downstream timing never sees the decode logic
  assign O_CMD_DATA   = cmd_data;
  assign O_CMD_VALID  = cmd_valid;
  assign O_CMD_END    = cmd_end;
  assign O_CMD_GLOBAL = cmd_global;
  assign O_ACK_REQ    = ack_req;
  assign O_TX_EN      = tx_en;
  assign O_NODE_ADDR  = node_addr;
  assign O_DELAY_MS   = delay_ms;

endmodule // rdaf_top
